// >>> logic/bmcd_regs.svh
`ifndef BMCD_REGS_SVH
`define BMCD_REGS_SVH
`define BMCD_CMD_MASKED_BL    8'h10
`define BMCD_CMD_INIT         8'h11
`define BMCD_CMD_READ_DATA    8'h12
`define BMCD_CMD_WRITE_DATA   8'h13
`define BMCD_CMD_READ_SEEK    8'h14
`define BMCD_CMD_RD_BL_REG    8'h15
`define BMCD_CMD_WR_BL_REG    8'h16
`define BMCD_CMD_WRITE_BL     8'h17
`define BMCD_CMD_CHAN_STATUS  8'h18
`define BMCD_CMD_ABORT        8'h19
`define BMCD_CMD_WRITE_SEEK   8'h1a
`define BMCD_CMD_READ_BL      8'h1b
`define BMCD_CMD_CORR_DATA    8'h1c
`define BMCD_CMD_FIFO_RESET   8'h1d
`define BMCD_CMD_PURGE        8'h1e
`define BMCD_CMD_SW_RESET     8'h1f
`define BMCD_CMD_CLEAR_INT    8'h20
`define BMCD_STATUS_DONE      8'h40
`define BMCD_BL_BYTES         6'h14
`define BMCD_WBL_BYTES        6'h28
`define BMCD_PAGE_BYTES_ECC   7'h40
`define BMCD_PAGE_BYTES_RAW   7'h44
`define BMCD_ONES_ECC         9'h10e
`define BMCD_ONES_RAW         9'h110
`define BMCD_CHAN_A           4'h0
`define BMCD_CHAN_BOTH        4'h1
`define BMCD_CORR_BYTES       6'h20
`define BMCD_PAGES_ALL        12'h800
`define BMCD_FIFO_DEPTH       6'h28
`define BMCD_BL_BITS          160
`endif

// >>> logic/bmcd_pkg.sv
package bmcd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_MASKED  = 4'b0001,
    ST_INIT    = 4'b0010,
    ST_READ    = 4'b0011,
    ST_WRITE   = 4'b0100,
    ST_SEEK    = 4'b0101,
    ST_BL_OUT  = 4'b0110,
    ST_BL_IN   = 4'b0111,
    ST_WBL     = 4'b1000,
    ST_STATUS  = 4'b1001,
    ST_CORR    = 4'b1010,
    ST_FINISH  = 4'b1011
  } bmcd_state_t;

  typedef struct packed {
    logic       write_protect_off;
    logic       internal_correction_enable;
    logic       user_correction_enable;
    logic       int_on_error;
    logic       int_on_done;
  } bmcd_enable_t;

  typedef struct packed {
    logic [3:0]  channels;
    logic [10:0] pages;
  } bmcd_blen_t;

  typedef struct packed {
    logic [3:0]  device_sel;
    logic [10:0] page;
  } bmcd_addr_t;

  typedef struct packed {
    logic       busy;
    logic       operation_done_flag;
    logic       op_fail;
    logic       timing_error;
    logic       fifo_ready;
  } bmcd_stat_t;
endpackage

// >>> logic/bmcd_decoder.sv
`timescale 1ns/1ps
module bmcd_decoder
  import bmcd_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // command port
  input  wire logic         cmd_wr,
  input  wire logic [7:0]   cmd_code,
  input  wire bmcd_enable_t enable_cfg,
  input  wire bmcd_blen_t   blen_cfg,
  input  wire bmcd_addr_t   addr_cfg,
  // host fifo port
  input  wire logic         host_fifo_wr,
  input  wire logic [7:0]   host_fifo_wdata,
  input  wire logic         host_fifo_rd,
  // channel side
  input  wire logic         chan_valid,
  input  wire logic [7:0]   chan_rdata,
  input  wire logic [7:0]   chan_status_a,
  input  wire logic [7:0]   chan_status_b,
  input  wire logic         chan_present_b,
  // outputs
  output logic [7:0]        host_fifo_rdata,
  output logic [7:0]        status_reg,
  output logic              irq,
  output logic              dma_req,
  output logic              chan_take,
  output logic [7:0]        chan_wdata,
  output logic              chan_sw_reset,
  output logic              device_run,
  output logic [10:0]       next_page,
  output logic              rac_at_fifo
);
`include "bmcd_regs.svh"

  bmcd_state_t state_reg;
  logic [7:0]  fifo_mem [0:39];
  logic [5:0]  wr_ptr_reg, rd_ptr_reg, count_reg;
  logic [11:0] pages_left_reg;
  logic [6:0]  byte_left_reg;
  logic [8:0]  ones_reg;
  logic [`BMCD_BL_BITS-1:0] boot_a_reg, boot_b_reg;
  logic [1:0]  chans_present_reg;
  logic        two_chan_reg, busy_reg, done_reg, fail_reg, terr_reg;
  logic [2:0]  cin_sync_reg;
  logic        abort_hold_reg;

  // decoded command strobes
  logic accept, is_abort, is_clear;
  assign is_abort = cmd_wr && cmd_code == `BMCD_CMD_ABORT;
  assign is_clear = cmd_wr && cmd_code == `BMCD_CMD_CLEAR_INT;
  assign accept   = cmd_wr && !busy_reg && cmd_code[7:4] == 4'h1
                    && !is_abort;

  function automatic logic both_sel(input logic [3:0] f);
    both_sel = (f == `BMCD_CHAN_BOTH);
  endfunction

  logic corr_on;
  assign corr_on = enable_cfg.internal_correction_enable
                   || enable_cfg.user_correction_enable;

  // fifo pointer moves; device side pushes on reads, pops on writes
  logic dev_push, dev_pop, h_push, h_pop, push, pop, fifo_clr;
  logic [7:0] push_data;
  assign h_push   = host_fifo_wr && count_reg != `BMCD_FIFO_DEPTH;
  assign h_pop    = host_fifo_rd && count_reg != 6'h00;
  assign push     = h_push || dev_push;
  assign pop      = h_pop || dev_pop;
  assign push_data = dev_push ? chan_rdata : host_fifo_wdata;
  assign fifo_clr = accept && (cmd_code == `BMCD_CMD_FIFO_RESET
                    || cmd_code == `BMCD_CMD_SW_RESET);

  logic stat_slot;
  logic [7:0] stat_byte;
  assign stat_byte = stat_slot ? chan_status_b : chan_status_a;
  // streaming states
  assign dev_push = (state_reg == ST_READ || state_reg == ST_BL_OUT ||
                     state_reg == ST_CORR || state_reg == ST_STATUS) &&
                    chan_valid && count_reg != `BMCD_FIFO_DEPTH && !h_push;
  assign dev_pop  = (state_reg == ST_WRITE || state_reg == ST_BL_IN ||
                     state_reg == ST_WBL || state_reg == ST_MASKED) &&
                    count_reg != 6'h00 && !h_pop;
  assign stat_slot = byte_left_reg == 7'h01;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= 6'h00;
      rd_ptr_reg <= 6'h00;
      count_reg  <= 6'h00;
    end else if (fifo_clr) begin
      wr_ptr_reg <= 6'h00;
      rd_ptr_reg <= 6'h00;
      count_reg  <= 6'h00;
    end else begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == `BMCD_FIFO_DEPTH - 6'h01) ? 6'h00
                      : wr_ptr_reg + 6'h01;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == `BMCD_FIFO_DEPTH - 6'h01) ? 6'h00
                      : rd_ptr_reg + 6'h01;
      count_reg <= count_reg + {5'h00, push} - {5'h00, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push)
      fifo_mem[wr_ptr_reg] <= (state_reg == ST_STATUS) ? stat_byte
                              : push_data;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      host_fifo_rdata <= 8'h00;
    else if (fifo_clr)
      host_fifo_rdata <= 8'h00;
    else
      host_fifo_rdata <= fifo_mem[rd_ptr_reg];
  end

  // sequencer
  logic [11:0] page_total;
  assign page_total = (blen_cfg.pages == 11'h000) ? `BMCD_PAGES_ALL
                      : {1'b0, blen_cfg.pages};
  logic [6:0] page_bytes;
  assign page_bytes = corr_on ? `BMCD_PAGE_BYTES_ECC : `BMCD_PAGE_BYTES_RAW;
  logic [8:0] ones_need;
  assign ones_need = corr_on ? `BMCD_ONES_ECC : `BMCD_ONES_RAW;

  logic moved, unit_end;
  assign moved    = dev_push || dev_pop || state_reg == ST_INIT ||
                    state_reg == ST_SEEK;
  assign unit_end = moved && byte_left_reg == 7'h01;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg      <= ST_IDLE;
      byte_left_reg  <= 7'h00;
      pages_left_reg <= 12'h000;
      two_chan_reg   <= 1'b0;
      fail_reg       <= 1'b0;
    end else if (is_abort) begin
      state_reg <= ST_FINISH;
    end else if (accept) begin
      two_chan_reg <= both_sel(blen_cfg.channels);
      fail_reg     <= 1'b0;
      case (cmd_code)
        `BMCD_CMD_MASKED_BL, `BMCD_CMD_WR_BL_REG: begin
          state_reg     <= (cmd_code == `BMCD_CMD_MASKED_BL) ? ST_MASKED
                           : ST_BL_IN;
          byte_left_reg <= {1'b0, `BMCD_BL_BYTES};
          pages_left_reg <= both_sel(blen_cfg.channels) ? 12'h002 : 12'h001;
        end
        `BMCD_CMD_INIT: begin
          state_reg      <= ST_INIT;
          byte_left_reg  <= 7'h02;
          pages_left_reg <= 12'h001;
        end
        `BMCD_CMD_READ_DATA, `BMCD_CMD_WRITE_DATA: begin
          state_reg <= (cmd_code == `BMCD_CMD_READ_DATA) ? ST_READ
                       : ST_WRITE;
          byte_left_reg  <= page_bytes;
          pages_left_reg <= page_total;
        end
        `BMCD_CMD_READ_SEEK, `BMCD_CMD_WRITE_SEEK: begin
          state_reg      <= ST_SEEK;
          byte_left_reg  <= 7'h01;
          pages_left_reg <= 12'h001;
        end
        `BMCD_CMD_RD_BL_REG, `BMCD_CMD_READ_BL: begin
          state_reg     <= ST_BL_OUT;
          byte_left_reg <= {1'b0, `BMCD_BL_BYTES};
          pages_left_reg <= (both_sel(blen_cfg.channels) ||
                  cmd_code == `BMCD_CMD_READ_BL) ? 12'h002 : 12'h001;
        end
        `BMCD_CMD_WRITE_BL: begin
          if (enable_cfg.write_protect_off) begin
            state_reg     <= ST_WBL;
            byte_left_reg <= {1'b0, `BMCD_WBL_BYTES};
            pages_left_reg <= 12'h001;
          end else begin
            state_reg <= ST_FINISH;
            fail_reg  <= 1'b1;
          end
        end
        `BMCD_CMD_CHAN_STATUS: begin
          state_reg      <= ST_STATUS;
          byte_left_reg  <= 7'h02;
          pages_left_reg <= 12'h001;
        end
        `BMCD_CMD_CORR_DATA: begin
          if (corr_on) begin
            state_reg     <= ST_CORR;
            byte_left_reg <= {1'b0, `BMCD_CORR_BYTES};
            pages_left_reg <= both_sel(blen_cfg.channels) ? 12'h002
                              : 12'h001;
          end else begin
            state_reg <= ST_FINISH;
            fail_reg  <= 1'b1;
          end
        end
        default: state_reg <= ST_FINISH;
      endcase
    end else begin
      case (state_reg)
        ST_IDLE, ST_FINISH: state_reg <= ST_IDLE;
        default: begin
          if (unit_end) begin
            if (pages_left_reg == 12'h001) begin
              state_reg <= ST_FINISH;
            end else begin
              pages_left_reg <= pages_left_reg - 12'h001;
              byte_left_reg  <= (state_reg == ST_READ ||
                                 state_reg == ST_WRITE) ? page_bytes
                                : {1'b0, `BMCD_BL_BYTES};
            end
          end else if (moved) begin
            byte_left_reg <= byte_left_reg - 7'h01;
          end
        end
      endcase
    end
  end

  // masked bootloop write: count ones, mask the excess
  logic [7:0] masked_byte;
  always_comb begin
    logic [8:0] n;
    n = ones_reg;
    masked_byte = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (fifo_mem[rd_ptr_reg][i] && n < ones_need) begin
        masked_byte[i] = 1'b1;
        n = n + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      ones_reg <= 9'h000;
    else if (accept)
      ones_reg <= 9'h000;
    else if (state_reg == ST_MASKED && dev_pop && unit_end)
      ones_reg <= 9'h000;
    else if (state_reg == ST_MASKED && dev_pop)
      ones_reg <= ones_reg + 9'(unsigned'($countones(masked_byte)));
  end

  // bootloop registers per channel, shifted in a byte at a time
  logic to_b;
  assign to_b = two_chan_reg && pages_left_reg == 12'h001;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      boot_a_reg <= '0;
      boot_b_reg <= '0;
    end else if (state_reg == ST_INIT && unit_end) begin
      boot_a_reg <= boot_a_reg | boot_b_reg;
      boot_b_reg <= boot_a_reg | boot_b_reg;
    end else if (dev_pop && (state_reg == ST_MASKED ||
                             state_reg == ST_BL_IN)) begin
      if (to_b)
        boot_b_reg <= {boot_b_reg[`BMCD_BL_BITS-9:0],
                       state_reg == ST_MASKED ? masked_byte
                       : fifo_mem[rd_ptr_reg]};
      else
        boot_a_reg <= {boot_a_reg[`BMCD_BL_BITS-9:0],
                       state_reg == ST_MASKED ? masked_byte
                       : fifo_mem[rd_ptr_reg]};
    end
  end

  // status and completion
  logic finishing;
  assign finishing = state_reg == ST_FINISH;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      terr_reg <= 1'b0;
    end else begin
      if (accept)
        busy_reg <= 1'b1;
      else if (finishing)
        busy_reg <= 1'b0;
      if (finishing)
        done_reg <= !fail_reg || is_abort;
      else if (accept || is_clear)
        done_reg <= 1'b0;
      if (busy_reg && ((host_fifo_wr && !h_push) ||
                       (host_fifo_rd && !h_pop)))
        terr_reg <= 1'b1;
      else if (is_abort || (accept && cmd_code == `BMCD_CMD_SW_RESET))
        terr_reg <= 1'b0;
    end
  end

  // abort status stands until the next command or a clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      abort_hold_reg <= 1'b0;
    else if (is_abort)
      abort_hold_reg <= 1'b1;
    else if (accept || is_clear)
      abort_hold_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      status_reg <= 8'h00;
    else if (is_abort)
      status_reg <= `BMCD_STATUS_DONE;
    else if (is_clear)
      status_reg <= 8'h00;
    else if (abort_hold_reg)
      status_reg <= `BMCD_STATUS_DONE;
    else
      status_reg <= {busy_reg, done_reg, 1'b0, fail_reg && !busy_reg,
                     terr_reg, 2'b00, count_reg != 6'h00};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      irq <= 1'b0;
    else if (finishing && ((enable_cfg.int_on_done && !fail_reg) ||
                           (enable_cfg.int_on_error && fail_reg)))
      irq <= 1'b1;
    else if (is_clear)
      irq <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      rac_at_fifo <= 1'b0;
    else
      rac_at_fifo <= is_clear ? 1'b1 : (accept ? 1'b0 : rac_at_fifo);
  end

  // dma request: half-empty on writes, half-full on reads; clear leaves it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      dma_req <= 1'b0;
    else if (!is_clear)
      dma_req <= (state_reg == ST_WRITE && count_reg <= `BMCD_BL_BYTES) ||
                 (state_reg == ST_READ && count_reg >= `BMCD_BL_BYTES);
  end

  // device side strobes and next page register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_take     <= 1'b0;
      chan_wdata    <= 8'h00;
      chan_sw_reset <= 1'b0;
      device_run    <= 1'b0;
      next_page     <= 11'h000;
      chans_present_reg <= 2'b00;
      cin_sync_reg  <= 3'b000;
    end else begin
      cin_sync_reg <= {cin_sync_reg[1:0], chan_present_b};
      chan_take  <= dev_pop;
      chan_wdata <= state_reg == ST_MASKED ? masked_byte
                    : fifo_mem[rd_ptr_reg];
      chan_sw_reset <= accept && cmd_code == `BMCD_CMD_SW_RESET;
      device_run <= !(is_abort || finishing) &&
                    (accept || (device_run && state_reg != ST_IDLE));
      if (state_reg == ST_INIT && unit_end) begin
        next_page <= 11'h000;
        // pin counts as present only once the last two stages agree
        chans_present_reg <= {cin_sync_reg[2] && cin_sync_reg[1], 1'b1};
      end else if (accept && cmd_code == `BMCD_CMD_PURGE)
        next_page <= 11'h000;
      else if (state_reg == ST_SEEK && unit_end)
        next_page <= addr_cfg.page + 11'h001;
      else if ((state_reg == ST_READ || state_reg == ST_WRITE) && unit_end)
        next_page <= next_page + 11'h001;
    end
  end
endmodule

// >>> bench/bmcd_decoder_props.sv
`timescale 1ns/1ps
module bmcd_decoder_props
  import bmcd_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         rstn,
  // command and fifo strobes
  input wire logic         cmd_wr,
  input wire logic [7:0]   cmd_code,
  input wire bmcd_enable_t enable_cfg,
  input wire logic         host_fifo_wr,
  input wire logic         host_fifo_rd,
  // watched outputs
  input wire logic [7:0]   status_reg,
  input wire logic         irq,
  input wire logic         dma_req,
  input wire logic         chan_sw_reset,
  input wire logic [10:0]  next_page,
  input wire logic         rac_at_fifo
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  logic accept;
  assign accept = cmd_wr && !status_reg[7] && cmd_code[7:4] == 4'h1
                  && cmd_code != 8'h19;

  sequence take_s(logic [7:0] c);
    cmd_wr && cmd_code == c && !status_reg[7];
  endsequence
  sequence failed_s;
    status_reg[4] && !status_reg[7];
  endsequence

  busy_on_accept_a: assert property (accept |-> ##2 status_reg[7])
    else $error("busy not raised after accepted command");
  abort_status_a: assert property (
    cmd_wr && cmd_code == 8'h19 |-> ##[1:2] status_reg == 8'h40)
    else $error("abort did not leave status 0x40");
  clear_int_a: assert property (
    cmd_wr && cmd_code == 8'h20 |-> ##[1:2] (!irq && rac_at_fifo))
    else $error("clear command left irq or address counter");
  dma_hold_a: assert property (
    cmd_wr && cmd_code == 8'h20 && !status_reg[7] && !host_fifo_wr
    && !host_fifo_rd |=> $stable(dma_req))
    else $error("clear command moved dma request");
  irq_cause_a: assert property (
    $rose(irq) |-> enable_cfg.int_on_done || enable_cfg.int_on_error)
    else $error("interrupt raised with no enable");
  irq_on_done_a: assert property (
    $fell(status_reg[7]) && status_reg[6] && enable_cfg.int_on_done
    |-> ##[0:2] irq)
    else $error("no interrupt on completion");
  wbl_guard_a: assert property (
    take_s(8'h17) ##0 !enable_cfg.write_protect_off |-> ##[3:8] failed_s)
    else $error("bootloop write ran without enable");
  corr_guard_a: assert property (
    take_s(8'h1c) ##0 !enable_cfg.internal_correction_enable
    && !enable_cfg.user_correction_enable |-> ##[3:8] failed_s)
    else $error("corrected read ran without correction enable");
  sw_reset_a: assert property (take_s(8'h1f) |-> ##[1:8] chan_sw_reset)
    else $error("software reset not sent to channels");
  purge_page_a: assert property (
    take_s(8'h1e) |-> ##[1:8] next_page == 11'h000)
    else $error("purge left next page");
  fifo_empty_a: assert property (
    take_s(8'h1d) |-> ##[3:8] (!status_reg[7] && !status_reg[0]))
    else $error("fifo not empty after reset command");
endmodule

bind bmcd_decoder bmcd_decoder_props bmcd_decoder_props_i (
  .clk(clk), .rstn(rstn), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
  .enable_cfg(enable_cfg), .host_fifo_wr(host_fifo_wr),
  .host_fifo_rd(host_fifo_rd), .status_reg(status_reg), .irq(irq),
  .dma_req(dma_req), .chan_sw_reset(chan_sw_reset),
  .next_page(next_page), .rac_at_fifo(rac_at_fifo)
);

// >>> bench/bmcd_chan_model.sv
`timescale 1ns/1ps
module bmcd_chan_model
  import bmcd_pkg::*;
#(
  parameter logic [7:0] STAT_A = 8'h3c,
  parameter logic [7:0] STAT_B = 8'hc3
)(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // pacing: one byte every fourth cycle when high
  input wire logic        slow,
  // channel lines
  output logic            chan_valid,
  output logic [7:0]      chan_rdata,
  output logic [7:0]      chan_status_a,
  output logic [7:0]      chan_status_b,
  output logic            chan_present_b
);
  logic [1:0] gap_reg;
  logic [7:0] byte_reg;
  logic       offer;

  assign chan_status_a = STAT_A;
  assign chan_status_b = STAT_B;
  assign chan_present_b = 1'b1;
  assign offer = !slow || gap_reg == 2'h3;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_reg <= 2'h0;
      byte_reg <= 8'h00;
      chan_valid <= 1'b0;
      chan_rdata <= 8'h00;
    end else begin
      gap_reg <= gap_reg + 2'h1;
      chan_valid <= offer;
      if (offer) begin
        byte_reg <= byte_reg + 8'h01;
        chan_rdata <= byte_reg;
      end else begin
        // a stale byte must not look valid, so it is inverted each cycle
        chan_rdata <= ~chan_rdata;
      end
    end
  end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import bmcd_pkg::*;
;
  typedef struct {
    logic [7:0] code;
    logic [4:0] en;
    logic       fail;
    logic       irq;
  } bmcd_row_t;

  localparam int LIMIT = 30000;
  logic         clk, rstn, cmd_wr, host_fifo_wr, host_fifo_rd, slow;
  logic [7:0]   cmd_code, host_fifo_wdata, chan_rdata;
  logic [7:0]   chan_status_a, chan_status_b, host_fifo_rdata;
  logic [7:0]   status_reg, chan_wdata;
  logic         chan_valid, chan_present_b, irq, dma_req, chan_take;
  logic         chan_sw_reset, device_run, rac_at_fifo;
  logic [10:0]  next_page;
  bmcd_enable_t enable_cfg;
  bmcd_blen_t   blen_cfg;
  bmcd_addr_t   addr_cfg;
  int           fails, checked, cycles, n;
  bmcd_row_t    rows [7] = '{
    '{8'h1d, 5'h00, 1'b0, 1'b0}, '{8'h18, 5'h01, 1'b0, 1'b1},
    '{8'h11, 5'h01, 1'b0, 1'b1}, '{8'h17, 5'h02, 1'b1, 1'b1},
    '{8'h1c, 5'h00, 1'b1, 1'b0}, '{8'h1e, 5'h01, 1'b0, 1'b1},
    '{8'h1f, 5'h00, 1'b0, 1'b0}};

  bmcd_decoder bmcd_decoder_i (.*);
  bmcd_chan_model bmcd_chan_model_i (.clk(clk), .rstn(rstn), .slow(slow),
    .chan_valid(chan_valid), .chan_rdata(chan_rdata),
    .chan_status_a(chan_status_a), .chan_status_b(chan_status_b),
    .chan_present_b(chan_present_b));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic issue(input logic [7:0] c);
    @(negedge clk);
    cmd_wr = 1'b1;
    cmd_code = c;
    @(negedge clk);
    cmd_wr = 1'b0;
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    repeat (3) @(negedge clk);
    while (status_reg[7] !== 1'b0 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    chk({10'h000, status_reg[7]}, 11'h000);
  endtask

  task automatic pop(input logic [7:0] e);
    repeat (2) @(negedge clk);
    chk({3'h0, host_fifo_rdata}, {3'h0, e});
    host_fifo_rd = 1'b1;
    @(negedge clk);
    host_fifo_rd = 1'b0;
  endtask

  // counts what is left in the fifo once the command is over
  task automatic drain(output int cnt);
    cnt = 0;
    repeat (2) @(negedge clk);
    while (status_reg[0] === 1'b1 && cnt < 60) begin
      host_fifo_rd = 1'b1;
      @(negedge clk);
      host_fifo_rd = 1'b0;
      repeat (2) @(negedge clk);
      cnt++;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    {cmd_wr, host_fifo_wr, host_fifo_rd, slow} = 4'h0;
    {cmd_code, host_fifo_wdata} = 16'h0000;
    enable_cfg = '0;
    blen_cfg = '{channels: 4'h1, pages: 11'h001};
    addr_cfg = '0;
    fails = 0;
    checked = 0;
    cycles = 0;
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    chk({3'h0, status_reg}, 11'h000);
    chk({9'h000, irq, device_run}, 11'h000);
    rstn = 1'b1;
    issue(8'h19);
    wait_idle();
    issue(8'h20);
    foreach (rows[i]) begin
      enable_cfg = rows[i].en;
      issue(rows[i].code);
      wait_idle();
      chk({10'h000, status_reg[4]}, {10'h000, rows[i].fail});
      chk({10'h000, irq}, {10'h000, rows[i].irq});
      if (rows[i].code == 8'h11 || rows[i].code == 8'h1e) begin
        chk(next_page, 11'h000);
      end
      if (rows[i].code == 8'h18) begin
        pop(chan_status_a);
        pop(chan_status_b);
      end
      issue(8'h20);
      repeat (2) @(negedge clk);
      chk({8'h00, irq, rac_at_fifo, status_reg[7]}, 11'h002);
    end
    enable_cfg = '0;
    for (int ch = 0; ch < 2; ch++) begin
      slow = ch[0];
      issue(8'h1d);
      wait_idle();
      blen_cfg.channels = ch[3:0];
      issue(8'h15);
      wait_idle();
      drain(n);
      chk(11'(n), ch == 0 ? 11'd20 : 11'd40);
    end
    blen_cfg.channels = 4'h0;
    for (int b = 0; b < 25; b++) begin
      @(negedge clk);
      host_fifo_wr = 1'b1;
      host_fifo_wdata = 8'(b);
      @(negedge clk);
      host_fifo_wr = 1'b0;
    end
    issue(8'h16);
    wait_idle();
    drain(n);
    chk(11'(n), 11'd5);
    blen_cfg.channels = 4'h1;
    issue(8'h1d);
    wait_idle();
    issue(8'h1b);
    wait_idle();
    drain(n);
    chk(11'(n), 11'd40);
    addr_cfg.page = 11'h005;
    issue(8'h14);
    wait_idle();
    chk(next_page, 11'h006);
    addr_cfg.page = 11'h009;
    issue(8'h1a);
    wait_idle();
    chk(next_page, 11'h00a);
    blen_cfg = '{channels: 4'h1, pages: 11'h000};
    slow = 1'b1;
    issue(8'h12);
    repeat (60) @(negedge clk);
    chk({10'h000, status_reg[7]}, 11'h001);
    issue(8'h18);
    repeat (4) @(negedge clk);
    chk({9'h000, status_reg[7], device_run}, 11'h003);
    issue(8'h19);
    repeat (3) @(negedge clk);
    chk({3'h0, status_reg}, 11'h040);
    chk({10'h000, device_run}, 11'h000);
    give_verdict();
  end
endmodule
